// >>> shared/prc_pkg.sv
// Shared constants, types and address helpers for the priority request control block
package prc_pkg;

  // Clock and acknowledge watchdog timing
  localparam int PRC_CLK_PERIOD_NS = 4;
  localparam int PRC_ACK_TIMEOUT_NS = 1000;
  localparam int PRC_ACK_CYCLES_INT = PRC_ACK_TIMEOUT_NS / PRC_CLK_PERIOD_NS;
  localparam int PRC_WD_W = 8;
  localparam logic [PRC_WD_W-1:0] PRC_ACK_LAST = PRC_WD_W'(PRC_ACK_CYCLES_INT - 1);

  // Request counts and widths
  localparam int PRC_NUM_INT = 10;
  localparam int PRC_NUM_CNT = 29;
  localparam int PRC_ADDR_W = 12;
  localparam int PRC_INT_IDX_W = 4;
  localparam int PRC_CNT_IDX_W = 5;

  // Bit positions of the synchronised pin bundle
  localparam int PRC_PIN_INT_LSB = 0;
  localparam int PRC_PIN_CNT_LSB = PRC_NUM_INT;
  localparam int PRC_PIN_TRAP = PRC_NUM_INT + PRC_NUM_CNT;
  localparam int PRC_PIN_PWR = PRC_PIN_TRAP + 1;
  localparam int PRC_PIN_W = PRC_PIN_PWR + 1;

  // Vector and counter address maps
  localparam logic [PRC_ADDR_W-1:0] PRC_INT_VEC_BASE = 12'h400;
  localparam logic [PRC_ADDR_W-1:0] PRC_INT_VEC_STEP = 12'h004;
  localparam logic [PRC_ADDR_W-1:0] PRC_CNT_ADDR_BASE = 12'h024;
  localparam logic [PRC_ADDR_W-1:0] PRC_CNT_ADDR_STEP = 12'h001;

  // Controller states, one-hot
  typedef enum logic [3:0] {
    PRC_START = 4'h1,
    PRC_IDLE = 4'h2,
    PRC_INT = 4'h4,
    PRC_CNT = 4'h8
  } prc_state_e;

  // Order code and instruction signals toward the sequence generator
  typedef struct packed {
    logic start;
    logic intr;
    logic cnt_instr;
  } prc_seq_s;

  // Address word placed on the processor write lines
  typedef struct packed {
    logic drive;
    logic [PRC_ADDR_W-1:0] addr;
  } prc_wl_s;

  localparam prc_seq_s PRC_SEQ_NONE = 3'h0;
  localparam prc_seq_s PRC_SEQ_START = 3'h4;
  localparam prc_seq_s PRC_SEQ_INT = 3'h2;
  localparam prc_seq_s PRC_SEQ_CNT = 3'h1;
  localparam prc_wl_s PRC_WL_IDLE = 13'h0000;

  // Vector address of an interrupt source
  function automatic logic [PRC_ADDR_W-1:0] prc_int_addr(input logic [PRC_INT_IDX_W-1:0] idx);
    return PRC_ADDR_W'(PRC_INT_VEC_BASE + PRC_ADDR_W'(idx) * PRC_INT_VEC_STEP);
  endfunction

  // Erasable location of a counter
  function automatic logic [PRC_ADDR_W-1:0] prc_cnt_addr(input logic [PRC_CNT_IDX_W-1:0] idx);
    return PRC_ADDR_W'(PRC_CNT_ADDR_BASE + PRC_ADDR_W'(idx) * PRC_CNT_ADDR_STEP);
  endfunction

endpackage

// >>> src/prc_prio_enc.sv
// Fixed priority encoder, lowest index wins
module prc_prio_enc #(
  parameter int N = 2,
  parameter int IW = 1
) (
  input wire logic [N-1:0] i_req,
  output logic o_any,
  output logic [IW-1:0] o_idx
);

  // Scan from the top so the lowest set bit is written last
  always_comb begin
    o_any = 1'b0;
    o_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_any = 1'b1;
        o_idx = IW'(i);
      end
    end
  end

endmodule

// >>> src/prc_priority_control.sv
// Priority control: start, interrupt and counter request arbitration

// What this block does
// [RULE_01] Interrupt sends interrupt order code and a twelve-bit vector toward the processor.
// [RULE_02] Ten interrupt vectors, each tied to one requesting function.
// [RULE_03] Vector goes onto write lines only on a read control pulse.
// [RULE_04] Fixed priority chain serves interrupts one at a time.
// [RULE_05] Decoded interrupt address from the processor advances or clears the chain.
// [RULE_06] Interrupt requests come from keyboard, telemetry and timer inputs.
// [RULE_07] Counter request sends instruction signal and twelve-bit counter address.
// [RULE_08] Counter instruction only delays the program; no interrupt entry.
// [RULE_09] Counter address goes onto write lines only on a read control pulse.
// [RULE_10] Fixed priority among 29 counters; only the winner is presented.
// [RULE_11] Decoded counter address from the processor updates counter priority.
// [RULE_12] Alarm when an incremental pulse is not serviced correctly.
// [RULE_13] Incremental pulses steer to their own counter location.
// [RULE_14] During start code, hold the time pulse generator at its final pulse.
// [RULE_15] Restart on program trap, power failure or interrupt control malfunction.
// [RULE_16] Requests stay pending until their decoded acknowledge arrives; start_req clears all pending requests except one rising in the same cycle.
// [RULE_17] New order codes are gated only at an instruction boundary; the start code is raised on start_req in any cycle.
module prc_priority_control
  import prc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [PRC_NUM_INT-1:0] i_int_req,
  input wire logic [PRC_NUM_CNT-1:0] i_cnt_pulse,
  input wire logic i_trap,
  input wire logic i_power_fail,
  input wire logic i_read_pulse,
  input wire logic i_end_instr,
  input wire logic [PRC_NUM_INT-1:0] i_int_ack_dec,
  input wire logic [PRC_NUM_CNT-1:0] i_cnt_ack_dec,
  input wire logic i_start_done,
  output prc_seq_s o_seq,
  output prc_wl_s o_wl,
  output logic o_alarm,
  output logic o_final_time_pulse_hold
);

  logic [PRC_PIN_W-1:0] pin_raw;
  logic [PRC_PIN_W-1:0] pin_s;
  logic [PRC_PIN_W-1:0] pin_d;
  logic [PRC_PIN_W-1:0] pin_rise;
  logic [PRC_NUM_INT-1:0] int_rise;
  logic [PRC_NUM_CNT-1:0] cnt_rise;
  logic trap_s;
  logic pwr_s;

  prc_state_e state;
  prc_state_e next_state;
  logic [PRC_NUM_INT-1:0] int_pend;
  logic [PRC_NUM_CNT-1:0] cnt_pend;
  logic [PRC_NUM_INT-1:0] next_int_pend;
  logic [PRC_NUM_CNT-1:0] next_cnt_pend;
  logic [PRC_INT_IDX_W-1:0] int_sel;
  logic [PRC_CNT_IDX_W-1:0] cnt_sel;
  logic [PRC_WD_W-1:0] wd;

  logic int_any;
  logic cnt_any;
  logic [PRC_INT_IDX_W-1:0] int_win;
  logic [PRC_CNT_IDX_W-1:0] cnt_win;
  logic int_ack_hit;
  logic cnt_ack_hit;
  logic wd_last;
  logic int_expire;
  logic cnt_expire;
  logic cnt_overrun;
  logic start_req;
  logic serving;
  logic wl_take;
  prc_seq_s next_seq;
  prc_wl_s next_wl;
  logic next_alarm;

  // Pins come from other logic domains, so all pass the synchroniser
  assign pin_raw = {i_power_fail, i_trap, i_cnt_pulse, i_int_req};

  prc_sync #(
    .W(PRC_PIN_W)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_d(pin_raw),
    .o_q(pin_s)
  );

  // Delayed copy of the synchronised pins for edge detection
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pin_d <= '0;
    end else begin
      pin_d <= pin_s;
    end
  end

  // Each rising request is one event; a held level asks only once
  assign pin_rise = pin_s & ~pin_d;
  assign int_rise = pin_rise[PRC_PIN_INT_LSB +: PRC_NUM_INT]; // RULE_06
  assign cnt_rise = pin_rise[PRC_PIN_CNT_LSB +: PRC_NUM_CNT]; // RULE_13
  assign trap_s = pin_s[PRC_PIN_TRAP];
  assign pwr_s = pin_s[PRC_PIN_PWR];

  // Interrupt chain over the ten vectors
  prc_prio_enc #(
    .N(PRC_NUM_INT),
    .IW(PRC_INT_IDX_W)
  ) u_int_enc (
    .i_req(int_pend),
    .o_any(int_any),
    .o_idx(int_win)
  );

  // Counter chain over the 29 counter locations
  prc_prio_enc #(
    .N(PRC_NUM_CNT),
    .IW(PRC_CNT_IDX_W)
  ) u_cnt_enc (
    .i_req(cnt_pend),
    .o_any(cnt_any),
    .o_idx(cnt_win)
  );

  // Acknowledge and watchdog decode
  assign int_ack_hit = i_int_ack_dec[int_sel]; // RULE_05
  assign cnt_ack_hit = i_cnt_ack_dec[cnt_sel]; // RULE_11
  assign wd_last = (wd == PRC_ACK_LAST);
  assign int_expire = (state == PRC_INT) && wd_last && !int_ack_hit;
  assign cnt_expire = (state == PRC_CNT) && wd_last && !cnt_ack_hit;
  // A second pulse on a counter still waiting means an increment is lost
  assign cnt_overrun = |(cnt_rise & cnt_pend & ~i_cnt_ack_dec); // RULE_12

  // A stuck interrupt handshake is treated as a control malfunction
  assign start_req = trap_s | pwr_s | int_expire; // RULE_15

  // Pending latches: a new request wins over its own acknowledge
  assign next_int_pend = (start_req ? '0 : (int_pend & ~i_int_ack_dec)) | int_rise; // RULE_16
  assign next_cnt_pend = (start_req ? '0 : (cnt_pend & ~i_cnt_ack_dec)) | cnt_rise; // RULE_16

  // Controller next state
  always_comb begin
    next_state = state;
    case (state)
      PRC_START: begin
        if (i_start_done) begin
          next_state = PRC_IDLE; // RULE_14
        end
      end
      PRC_IDLE: begin
        // Counters only delay the program, so they go ahead of interrupts
        if (i_end_instr && cnt_any) begin
          next_state = PRC_CNT; // RULE_17
        end else if (i_end_instr && int_any) begin
          next_state = PRC_INT; // RULE_17
        end
      end
      PRC_INT: begin
        if (int_ack_hit) begin
          next_state = PRC_IDLE; // RULE_05
        end
      end
      PRC_CNT: begin
        if (cnt_ack_hit || cnt_expire) begin
          next_state = PRC_IDLE; // RULE_11
        end
      end
      default: begin
        next_state = PRC_START;
      end
    endcase
    if (start_req) begin
      next_state = PRC_START; // RULE_15
    end
  end

  // Outputs toward the sequence generator follow the next state
  assign next_seq = (next_state == PRC_START) ? PRC_SEQ_START :
                    (next_state == PRC_INT) ? PRC_SEQ_INT : // RULE_01
                    (next_state == PRC_CNT) ? PRC_SEQ_CNT : // RULE_08
                    PRC_SEQ_NONE;

  // Write lines are driven for one cycle after a read pulse while serving
  assign serving = (state == PRC_INT) || (state == PRC_CNT);
  assign wl_take = i_read_pulse && serving && !start_req; // RULE_03 RULE_09
  assign next_wl.drive = wl_take;
  assign next_wl.addr = !wl_take ? '0 :
                        (state == PRC_INT) ? prc_int_addr(int_sel) : // RULE_02
                        prc_cnt_addr(cnt_sel); // RULE_10
  assign next_alarm = (o_alarm & ~start_req) | cnt_overrun | cnt_expire; // RULE_12

  // State, pending bits and the served index
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state <= PRC_START;
      int_pend <= '0;
      cnt_pend <= '0;
      int_sel <= '0;
      cnt_sel <= '0;
    end else begin
      state <= next_state;
      int_pend <= next_int_pend;
      cnt_pend <= next_cnt_pend;
      // Winner is frozen for the whole service so only one address shows
      if (state == PRC_IDLE && next_state == PRC_INT) begin
        int_sel <= int_win; // RULE_04
      end
      if (state == PRC_IDLE && next_state == PRC_CNT) begin
        cnt_sel <= cnt_win; // RULE_10
      end
    end
  end

  // Acknowledge watchdog, restarted on every state change
  // A stalled counter only alarms and retries; a stalled interrupt forces a restart
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      wd <= '0;
    end else if (!serving || next_state != state) begin
      wd <= '0;
    end else begin
      wd <= wd + 1'b1;
    end
  end

  // Registered outputs
  // Reset leaves the block in start with the timer held, as after a fresh start
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_seq <= PRC_SEQ_START;
      o_wl <= PRC_WL_IDLE;
      o_alarm <= 1'b0;
      o_final_time_pulse_hold <= 1'b1;
    end else begin
      o_seq <= next_seq;
      o_wl <= next_wl;
      o_alarm <= next_alarm;
      o_final_time_pulse_hold <= (next_state == PRC_START); // RULE_14
    end
  end

  // Checks on the handshakes with the sequence generator and processor
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  start_hold_a: assert property ( // RULE_14
    (trap_s || pwr_s) |=> (o_seq.start && o_final_time_pulse_hold)
  ) else $error("start code issued without timer hold");

  hold_release_a: assert property ( // RULE_14
    (state == PRC_START && i_start_done && !start_req) |=> !o_final_time_pulse_hold
  ) else $error("timer hold not released after start done");

  wl_read_only_a: assert property ( // RULE_03
    o_wl.drive |-> $past(i_read_pulse) && ($past(state) inside {PRC_INT, PRC_CNT})
  ) else $error("write lines driven without read pulse");

  int_vector_a: assert property ( // RULE_01
    (state == PRC_INT && i_read_pulse && !start_req && !int_ack_hit)
      |=> (o_wl.drive && o_wl.addr == prc_int_addr($past(int_sel)) && o_seq.intr)
  ) else $error("interrupt vector not presented");

  cnt_address_a: assert property ( // RULE_09
    (state == PRC_CNT && i_read_pulse && !start_req)
      |=> (o_wl.drive && o_wl.addr == prc_cnt_addr($past(cnt_sel)))
  ) else $error("counter address not presented");

  one_order_a: assert property ( // RULE_04
    $onehot0(o_seq)
  ) else $error("more than one order code active");

  boundary_gate_a: assert property ( // RULE_17
    ($rose(o_seq.intr) || $rose(o_seq.cnt_instr)) |-> $past(i_end_instr)
  ) else $error("order code raised off an instruction boundary");

  int_advance_a: assert property ( // RULE_05
    (state == PRC_INT && int_ack_hit && !start_req) |=> (state == PRC_IDLE && !o_seq.intr)
  ) else $error("interrupt chain did not advance on acknowledge");

  pend_kept_a: assert property ( // RULE_16
    (int_pend != '0 && i_int_ack_dec == '0 && !start_req) |=> (int_pend != '0)
  ) else $error("pending interrupt lost without acknowledge");

  cnt_no_int_a: assert property ( // RULE_08
    (state == PRC_CNT) |-> !o_seq.intr ##1 (!o_seq.intr || $past(next_state) == PRC_INT)
  ) else $error("counter service entered interrupt");

  overrun_alarm_a: assert property ( // RULE_12
    (cnt_overrun && !start_req) |=> o_alarm [*2]
  ) else $error("lost increment raised no alarm");

  int_watchdog_a: assert property ( // RULE_15
    (state == PRC_INT && wd == PRC_ACK_LAST && !int_ack_hit) |=> state == PRC_START
  ) else $error("stalled interrupt did not restart");

  cnt_watchdog_a: assert property ( // RULE_12
    (state == PRC_CNT && wd == PRC_ACK_LAST && !cnt_ack_hit && !start_req)
      |=> (o_alarm && state == PRC_IDLE)
  ) else $error("stalled counter raised no alarm");

endmodule

// >>> src/prc_sync.sv
// Two flip-flop synchroniser for a bundle of pin inputs
module prc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end

endmodule

// >>> tb/prc_seq_model.sv
// Behavioural sequence generator and processor facing the priority control block
module prc_seq_model
  import prc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_slow,
  input wire logic i_mute,
  input wire prc_seq_s i_seq,
  input wire prc_wl_s i_wl,
  output logic o_read_pulse,
  output logic o_end_instr,
  output logic [PRC_NUM_INT-1:0] o_int_ack,
  output logic [PRC_NUM_CNT-1:0] o_cnt_ack,
  output logic o_start_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int cyc = 0;
  logic is_int;
  logic [PRC_ADDR_W-1:0] got;

  // One service at a time: read pulse, take the address, return it decoded
  initial begin
    {o_read_pulse, o_end_instr, o_int_ack, o_cnt_ack, o_start_done} = '0;
    forever begin
      @(posedge i_clk_sys);
      cyc <= cyc + 1;
      // Boundaries only while idle, so a service is never cut short
      o_end_instr <= i_resetn && i_seq == PRC_SEQ_NONE && cyc % 4 == 0;
      if (i_resetn && i_seq.start) begin
        repeat (3) @(posedge i_clk_sys);
        o_start_done <= 1'b1;
        @(posedge i_clk_sys);
        o_start_done <= 1'b0;
        // A muted processor never reads nor acknowledges, so the watchdogs run out
      end else if (i_resetn && !i_mute && (i_seq.intr || i_seq.cnt_instr)) begin
        is_int = i_seq.intr;
        // A slow processor keeps the block waiting before the read
        repeat (i_slow ? 6 : 1) @(posedge i_clk_sys);
        o_read_pulse <= 1'b1;
        @(posedge i_clk_sys);
        o_read_pulse <= 1'b0;
        @(posedge i_clk_sys);
        got = i_wl.addr;
        if (is_int) o_int_ack <= PRC_NUM_INT'(1) << ((got - PRC_INT_VEC_BASE) >> 2);
        else o_cnt_ack <= PRC_NUM_CNT'(1) << (got - PRC_CNT_ADDR_BASE);
        @(posedge i_clk_sys);
        o_int_ack <= '0;
        o_cnt_ack <= '0;
      end
    end
  end
endmodule

// >>> tb/priority_request_control_bench.sv
// Self-checking bench for the priority request control block
module priority_request_control_bench
  import prc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic slow = 1'b0;
  logic mute = 1'b0;
  logic trap = 1'b0;
  logic power_fail = 1'b0;
  logic [PRC_NUM_INT-1:0] int_req = '0;
  logic [PRC_NUM_CNT-1:0] cnt_pulse = '0;
  logic read_pulse, end_instr, start_done, alarm, hold;
  logic [PRC_NUM_INT-1:0] int_ack;
  logic [PRC_NUM_CNT-1:0] cnt_ack;
  prc_seq_s seq;
  prc_wl_s wl;
  logic exp_alarm = 1'b0;
  int exp_q[$];
  int fails = 0;
  int n_compared = 0;

  prc_priority_control i_dut (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_int_req(int_req), .i_cnt_pulse(cnt_pulse),
    .i_trap(trap), .i_power_fail(power_fail), .i_read_pulse(read_pulse),
    .i_end_instr(end_instr), .i_int_ack_dec(int_ack), .i_cnt_ack_dec(cnt_ack),
    .i_start_done(start_done), .o_seq(seq), .o_wl(wl), .o_alarm(alarm),
    .o_final_time_pulse_hold(hold)
  );
  prc_seq_model i_partner (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_slow(slow), .i_mute(mute), .i_seq(seq),
    .i_wl(wl), .o_read_pulse(read_pulse), .o_end_instr(end_instr), .o_int_ack(int_ack),
    .o_cnt_ack(cnt_ack), .o_start_done(start_done)
  );

  // 250 MHz system clock
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // Comparisons, one per kind of result
  task automatic cmp_addr(input logic [PRC_ADDR_W-1:0] got, input logic [PRC_ADDR_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t addr got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_seq(input prc_seq_s got, input prc_seq_s exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t order got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t flag got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_count(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      fails++;
      $display("[ERR] t=%0t cycles got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Bounded wait until every predicted service was seen and the block is idle
  task automatic drain();
    int k;
    k = 0;
    while (k < 6000 && (exp_q.size() != 0 || seq !== PRC_SEQ_NONE)) begin
      tick(1);
      k++;
    end
    if (k == 6000) begin
      fails++;
      $display("[ERR] t=%0t wait ran out, left %h exp %h", $time, exp_q.size(), 0);
      complete_run();
    end
  endtask

  // Bounded wait for an order code, returning the cycles it took
  task automatic wait_seq(input prc_seq_s want, output int n);
    n = 0;
    while (n < 1000 && seq !== want) begin
      tick(1);
      n++;
    end
    if (n == 1000) begin
      fails++;
      $display("[ERR] t=%0t order wait ran out, got %h exp %h", $time, seq, want);
      complete_run();
    end
  endtask

  // Raise requests together; reference order is counters first, then lowest index
  task automatic request(input logic [PRC_NUM_INT-1:0] im, input logic [PRC_NUM_CNT-1:0] cm);
    for (int i = 0; i < PRC_NUM_CNT; i++) if (cm[i]) exp_q.push_back(PRC_CNT_ADDR_BASE + i);
    for (int i = 0; i < PRC_NUM_INT; i++) if (im[i]) exp_q.push_back(PRC_INT_VEC_BASE + 4 * i);
    int_req <= im;
    cnt_pulse <= cm;
    tick(4);
    int_req <= '0;
    cnt_pulse <= '0;
    tick(1);
  endtask

  task automatic end_test(input string name);
    cmp_bit(alarm, exp_alarm);
    $display("test done: %s", name);
  endtask

  // Each address driven must be the next one predicted, with the matching order code
  always @(posedge clk_sys) begin
    if (resetn) begin
      cmp_bit($onehot0(seq), 1'b1);
      if (!wl.drive) cmp_addr(wl.addr, 12'h000);
      else if (exp_q.size() == 0) cmp_addr(wl.addr, 12'hfff);
      else begin
        cmp_addr(wl.addr, exp_q[0][11:0]);
        cmp_seq(seq, exp_q[0] >= PRC_INT_VEC_BASE ? PRC_SEQ_INT : PRC_SEQ_CNT);
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    int k;
    void'($urandom(12));
    tick(5);
    cmp_seq(seq, PRC_SEQ_START);
    cmp_bit(hold, 1'b1);
    tick(1);
    resetn <= 1'b1;
    drain();
    cmp_bit(hold, 1'b0);
    end_test("reset and start");
    request('1, '1);
    drain();
    end_test("all sources at once");
    for (int r = 0; r < 6; r++) begin
      slow <= r[0];
      request(PRC_NUM_INT'($urandom), PRC_NUM_CNT'($urandom));
      drain();
    end
    end_test("random mixes");
    // Second increment on a counter that is still waiting for service
    slow <= 1'b1;
    request('0, 29'h1000_0003);
    cnt_pulse[28] <= 1'b1;
    tick(3);
    cnt_pulse[28] <= 1'b0;
    exp_alarm = 1'b1;
    drain();
    end_test("lost increment");
    for (int s = 0; s < 2; s++) begin
      trap <= (s == 0);
      power_fail <= (s == 1);
      tick(25);
      cmp_seq(seq, PRC_SEQ_START);
      cmp_bit(hold, 1'b1);
      exp_alarm = 1'b0;
      trap <= 1'b0;
      power_fail <= 1'b0;
      drain();
      end_test("restart source");
    end
    // A processor that never answers: a counter only alarms, an interrupt restarts
    mute <= 1'b1;
    request('0, 29'h0000_0004);
    tick(300);
    cmp_bit(alarm, 1'b1);
    mute <= 1'b0;
    exp_alarm = 1'b1;
    drain();
    end_test("stalled counter");
    mute <= 1'b1;
    int_req <= 10'h004;
    wait_seq(PRC_SEQ_INT, k);
    int_req <= '0;
    wait_seq(PRC_SEQ_START, k);
    cmp_count(k, PRC_ACK_CYCLES_INT);
    mute <= 1'b0;
    exp_alarm = 1'b0;
    drain();
    end_test("stalled interrupt");
    slow <= 1'b0;
    request(10'h201, 29'h0000_0000);
    drain();
    end_test("service after restart");
    complete_run();
  end
endmodule
